// File: card_irq_regs.vh
// Register offsets, field positions and reset values of the event source block
`ifndef CARD_IRQ_REGS_VH
`define CARD_IRQ_REGS_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define OFS_RAW_EVENT_FLAGS 12'h000
`define OFS_EVENT_MASK      12'h004
`define OFS_EVENT_CLEAR     12'h008

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define BIT_BUSY_END        10
`define BIT_CMD_SENT        11
`define BIT_LINE3_HIGH      12
`define BIT_LINE3_LOW       13
`define BIT_RESP_CRC        14
`define BIT_RESP_AVAIL      15
`define BIT_DATA_CRC        16
`define BIT_DATA_DONE       17
`define BIT_SDIO_IRQ        18
`define BIT_LINE3_LIVE      19
`define LOW_EVENT_COUNT     10
`define EVENT_COUNT         19

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_RAW_EVENT_FLAGS 19'h00000
`define RST_EVENT_MASK      19'h7FFFF
`define RST_READ_DATA       32'h00000000

`endif

// File: event_flag_bank.v
// Sticky event flags, set by hardware and cleared by software
`timescale 1ns/1ps
`default_nettype none

module event_flag_bank #(
  parameter WIDTH = 19
) (
  // Clock and reset
  input  wire             clk,
  input  wire             rst,
  // Set and clear vectors
  input  wire [WIDTH-1:0] setVec,
  input  wire [WIDTH-1:0] clrVec,
  // Flags
  output reg  [WIDTH-1:0] flags_r
);

  wire [WIDTH-1:0] flags_nxt;

  // ----------------------------------------------------------------
  // Set wins over clear in the same cycle
  // ----------------------------------------------------------------
  assign flags_nxt = (flags_r & ~clrVec) | setVec;

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      flags_r <= {WIDTH{1'b0}};
    end
    else
    begin
      flags_r <= flags_nxt;
    end
  end

endmodule

`default_nettype wire

// File: card_host_irq_sources.v
// Event source register, mask, clear and interrupt pin of the card host
//
// What this block does
// - Read-only raw flag register at 0x00, reset zero
// - Software polls flags or finds interrupt cause
// - Bit 19 reads live line three level
// - Bit 18 sets on SDIO card interrupt
// - Card interrupt cleared here and at card
// - Bit 17 sets when data transfer finishes
// - Bit 16 sets on data CRC failure
// - Bit 15 sets when response is buffered
// - Bit 14 sets on response CRC failure
// - Bit 13 sets when idle and line low
// - Bit 12 sets when idle and line high
// - Bit 11 sets when command fully sent
// - Per-source mask, one masks, all masked
// - Writing one to clear register clears flag
// - Bit 10 sets when card busy ends
`include "card_irq_regs.vh"
`timescale 1ns/1ps
`default_nettype none

module card_host_irq_sources #(
  parameter ADDR_WIDTH = 12
) (
  // Clock and reset
  input  wire                  clk,
  input  wire                  rst,
  // Register port
  input  wire [ADDR_WIDTH-1:0] regAddr,
  input  wire                  regWrEn,
  input  wire                  regRdEn,
  input  wire [31:0]           regWrData,
  output reg  [31:0]           regRdData_r,
  output reg                   regRdValid_r,
  // Card-side event pulses
  input  wire                  cmdSent,
  input  wire                  respAvail,
  input  wire                  respCrcFail,
  input  wire                  dataDone,
  input  wire                  dataCrcFail,
  input  wire                  busyEnd,
  // Card-side levels
  input  wire                  sdioCardIrq,
  input  wire                  dataIdle,
  input  wire                  cardDataLineThree,
  // Lower event pulses from the FIFO and busy logic
  input  wire [`LOW_EVENT_COUNT-1:0] lowEvents,
  // Interrupt pin
  output reg                   irq_r
);

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  function addrHit;
    input [ADDR_WIDTH-1:0] addr;
    input [11:0]           ofs;
    begin
      addrHit = (addr == ofs[ADDR_WIDTH-1:0]);
    end
  endfunction

  function lineIdleAt;
    input idle;
    input line;
    input level;
    begin
      lineIdleAt = idle & (line == level);
    end
  endfunction

  wire hitFlags;
  wire hitMask;
  wire hitClear;

  // Full-width compare, so unmapped offsets read zero
  assign hitFlags = addrHit(regAddr, `OFS_RAW_EVENT_FLAGS);
  assign hitMask  = addrHit(regAddr, `OFS_EVENT_MASK);
  assign hitClear = addrHit(regAddr, `OFS_EVENT_CLEAR);

  // ----------------------------------------------------------------
  // Access strobes
  // ----------------------------------------------------------------
  // Writes to the flag register itself fall on nothing
  // Strobes last one cycle per access
  wire wrMask;
  wire wrClear;

  assign wrMask  = regWrEn & hitMask;
  assign wrClear = regWrEn & hitClear;

  // ----------------------------------------------------------------
  // Line three level and event sources
  // ----------------------------------------------------------------
  reg                     line3LiveLevel_r;
  wire                    line3LiveLevel_nxt;
  reg  [`EVENT_COUNT-1:0] setVec;
  reg  [`EVENT_COUNT-1:0] clrVec;
  wire [`EVENT_COUNT-1:0] rawFlags;

  // Bit 19 is a level, never a sticky flag
  assign line3LiveLevel_nxt = cardDataLineThree;

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      line3LiveLevel_r <= 1'b0;
    end
    else
    begin
      line3LiveLevel_r <= line3LiveLevel_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Lower event sources
  // ----------------------------------------------------------------
  // Lower flags come from the FIFO and busy logic
  wire [`LOW_EVENT_COUNT-1:0] setLow;

  assign setLow = lowEvents;

  // ----------------------------------------------------------------
  // Upper event sources
  // ----------------------------------------------------------------
  // Idle line flags are levels and re-set while the condition holds
  wire setBusyEnd;
  wire setCmdSent;
  wire setLineHigh;
  wire setLineLow;
  wire setRespCrc;
  wire setRespAvail;
  wire setDataCrc;
  wire setDataDone;
  wire setSdioIrq;

  assign setBusyEnd   = busyEnd;
  assign setCmdSent   = cmdSent;
  assign setLineHigh  = lineIdleAt(dataIdle, cardDataLineThree, 1'b1);
  assign setLineLow   = lineIdleAt(dataIdle, cardDataLineThree, 1'b0);
  assign setRespCrc   = respCrcFail;
  assign setRespAvail = respAvail;
  assign setDataCrc   = dataCrcFail;
  assign setDataDone  = dataDone;
  // Card interrupt re-sets its flag until the card drops it
  assign setSdioIrq   = sdioCardIrq;

  always @*
  begin
    setVec = {`EVENT_COUNT{1'b0}};
    setVec[`LOW_EVENT_COUNT-1:0] = setLow;
    setVec[`BIT_BUSY_END]   = setBusyEnd;
    setVec[`BIT_CMD_SENT]   = setCmdSent;
    setVec[`BIT_LINE3_HIGH] = setLineHigh;
    setVec[`BIT_LINE3_LOW]  = setLineLow;
    setVec[`BIT_RESP_CRC]   = setRespCrc;
    setVec[`BIT_RESP_AVAIL] = setRespAvail;
    setVec[`BIT_DATA_CRC]   = setDataCrc;
    setVec[`BIT_DATA_DONE]  = setDataDone;
    setVec[`BIT_SDIO_IRQ]   = setSdioIrq;
  end

  // ----------------------------------------------------------------
  // Clear register and raw flags
  // ----------------------------------------------------------------
  // A set in the same cycle as a clear wins
  always @*
  begin
    clrVec = {`EVENT_COUNT{1'b0}};
    if (wrClear)
    begin
      clrVec = regWrData[`EVENT_COUNT-1:0];
    end
  end

  event_flag_bank #(
    .WIDTH (`EVENT_COUNT)
  ) flagBank (
    .clk     (clk),
    .rst     (rst),
    .setVec  (setVec),
    .clrVec  (clrVec),
    .flags_r (rawFlags)
  );

  // ----------------------------------------------------------------
  // Mask register
  // ----------------------------------------------------------------
  // All sources start masked so the pin stays quiet after reset
  reg [`EVENT_COUNT-1:0] mask_r;
  reg [`EVENT_COUNT-1:0] mask_nxt;

  always @*
  begin
    mask_nxt = mask_r;
    if (wrMask)
    begin
      mask_nxt = regWrData[`EVENT_COUNT-1:0];
    end
  end

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      mask_r <= `RST_EVENT_MASK;
    end
    else
    begin
      mask_r <= mask_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt pin
  // ----------------------------------------------------------------
  // Pin follows the unmasked raw flags one cycle later, so a clear drops it
  wire [`EVENT_COUNT-1:0] pending;
  wire                    irq_nxt;

  assign pending = rawFlags & ~mask_r;
  assign irq_nxt = |pending;

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      irq_r <= 1'b0;
    end
    else
    begin
      irq_r <= irq_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  reg [31:0] flagsWord;
  reg [31:0] maskWord;
  reg [31:0] rdMux;

  // Bit 19 shows the sampled line level beside the flags
  always @*
  begin
    flagsWord = `RST_READ_DATA;
    flagsWord[`EVENT_COUNT-1:0] = rawFlags;
    flagsWord[`BIT_LINE3_LIVE]  = line3LiveLevel_r;
  end

  always @*
  begin
    maskWord = `RST_READ_DATA;
    maskWord[`EVENT_COUNT-1:0] = mask_r;
  end

  // Unmapped and write-only offsets read zero
  always @*
  begin
    rdMux = `RST_READ_DATA;
    if (hitFlags)
    begin
      rdMux = flagsWord;
    end
    else if (hitMask)
    begin
      rdMux = maskWord;
    end
  end

  // Read data holds from one read to the next
  reg [31:0] regRdData_nxt;
  reg        regRdValid_nxt;

  always @*
  begin
    regRdValid_nxt = regRdEn;
    regRdData_nxt  = regRdData_r;
    if (regRdEn)
    begin
      regRdData_nxt = rdMux;
    end
  end

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      regRdData_r  <= `RST_READ_DATA;
      regRdValid_r <= 1'b0;
    end
    else
    begin
      regRdValid_r <= regRdValid_nxt;
      regRdData_r  <= regRdData_nxt;
    end
  end

endmodule

`default_nettype wire

// File: card_irq_properties.sv
// Checker for the card host event source block
`timescale 1ns/1ps
`default_nettype none
module card_irq_props #(parameter ADDR_WIDTH = 12) (
  input wire logic clk, rst, regWrEn, regRdEn, regRdValid_r, irq_r,
  input wire logic [ADDR_WIDTH-1:0] regAddr,
  input wire logic [31:0] regWrData, regRdData_r,
  input wire logic cmdSent, respAvail, respCrcFail, dataDone, dataCrcFail,
  input wire logic busyEnd, sdioCardIrq, dataIdle, cardDataLineThree,
  input wire logic [9:0] lowEvents
);
  logic rd0, setAny, maskWr_r;
  assign rd0 = regRdEn && regAddr == 12'h000;
  assign setAny = |{cmdSent, respAvail, respCrcFail, dataDone, dataCrcFail,
    busyEnd, sdioCardIrq, dataIdle, lowEvents};
  always_ff @(posedge clk or posedge rst)
    if (rst)
      maskWr_r <= 1'b0;
    else if (regWrEn && regAddr == 12'h004)
      maskWr_r <= 1'b1;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_read_valid: assert property (regRdEn |=> regRdValid_r)
    else $error("read not answered");
  a_upper_zero: assert property (regRdValid_r |-> !(|regRdData_r[31:20]))
    else $error("reserved bits set");
  a_line3_live: assert property (rd0 && !$past(rst) |=>
    regRdData_r[19] == $past(cardDataLineThree, 2)) else $error("bad line");
  a_cmd_flag: assert property (rd0 && $past(cmdSent) |=> regRdData_r[11])
    else $error("command flag lost");
  a_done_flag: assert property (rd0 && $past(dataDone) |=> regRdData_r[17])
    else $error("done flag lost");
  a_sdio_flag: assert property (rd0 && $past(sdioCardIrq) |=> regRdData_r[18])
    else $error("card irq flag lost");
  a_clear_drops: assert property (regWrEn && regAddr == 12'h008 &&
    (&regWrData[18:0]) && !setAny |-> ##2 !irq_r) else $error("irq stuck");
  a_masked_quiet: assert property (!maskWr_r |-> !irq_r)
    else $error("irq while masked");
  cover property ($rose(irq_r));
  cover property (rd0);
  cover property (regWrEn && regAddr == 12'h008);
endmodule
bind card_host_irq_sources card_irq_props #(.ADDR_WIDTH(ADDR_WIDTH)) u_props (.*);
`default_nettype wire

// File: card_model.sv
// Card-side model: command and data events, card interrupt, line three
`timescale 1ns/1ps
`default_nettype none
module card_model (
  input  wire logic       clk,
  output var  logic [5:0] ev,
  output var  logic       sdioIrq, idle, line3
);
  initial {ev, sdioIrq, idle, line3} = 9'h000;
  task automatic fire(input int k);
    @(posedge clk) ev <= 6'h01 << k;
    @(posedge clk) ev <= 6'h00;
  endtask
  // Card interrupt holds until the card itself drops it
  task automatic levels(input logic i, d, l);
    @(posedge clk) {sdioIrq, idle, line3} <= {i, d, l};
  endtask
endmodule
`default_nettype wire

// File: card_host_irq_sources_tb.sv
// Testbench for the card host event source block
`timescale 1ns/1ps
`default_nettype none
module card_host_irq_sources_tb;
  logic        clk = 1'b0, rst = 1'b1, regWrEn = 1'b0, regRdEn = 1'b0;
  logic [11:0] regAddr = 12'h000;
  logic [31:0] regWrData = 32'h00000000, regRdData_r;
  logic [9:0]  lowEvents = 10'h000;
  logic        regRdValid_r, irq_r, sdioCardIrq, dataIdle, cardDataLineThree;
  logic [5:0]  ev;
  int          n_mismatch = 0, num_checks = 0;
  int          evBit [6] = '{11, 15, 14, 17, 16, 10};
  initial forever #2.5 clk = ~clk;
  card_model card (.clk(clk), .ev(ev), .sdioIrq(sdioCardIrq),
    .idle(dataIdle), .line3(cardDataLineThree));
  card_host_irq_sources DUT (.*, .cmdSent(ev[0]), .respAvail(ev[1]),
    .respCrcFail(ev[2]), .dataDone(ev[3]), .dataCrcFail(ev[4]),
    .busyEnd(ev[5]));
  task automatic cmp(input string nm, input logic [31:0] e, g);
    num_checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    regAddr <= a;
    regWrData <= d;
    regWrEn <= 1'b1;
    @(posedge clk) regWrEn <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    @(posedge clk);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge clk) regRdEn <= 1'b0;
    #1 cmp("valid", 32'h1, {31'h0, regRdValid_r});
    cmp("read data", e, regRdData_r);
  endtask
  task automatic waitc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    print_verdict;
  end
  initial
  begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rd(12'h000, 32'h0);
    rd(12'h004, 32'h0007FFFF);
    wr(12'h000, 32'hFFFFFFFF);
    rd(12'h000, 32'h0);
    rd(12'h00C, 32'h0);
    for (int k = 0; k < 6; k++)
    begin
      card.fire(k);
      rd(12'h000, 32'h1 << evBit[k]);
      cmp("irq masked", 32'h0, {31'h0, irq_r});
      wr(12'h008, 32'h1 << evBit[k]);
      rd(12'h000, 32'h0);
    end
    wr(12'h004, 32'h0007F7FF);
    card.fire(0);
    waitc(2);
    cmp("irq set", 32'h1, {31'h0, irq_r});
    wr(12'h008, 32'h00000800);
    waitc(2);
    cmp("irq clear", 32'h0, {31'h0, irq_r});
    card.levels(1'b1, 1'b0, 1'b0);
    wr(12'h008, 32'h00040000);
    rd(12'h000, 32'h00040000);
    card.levels(1'b0, 1'b0, 1'b0);
    wr(12'h008, 32'h00040000);
    rd(12'h000, 32'h0);
    card.levels(1'b0, 1'b0, 1'b1);
    card.levels(1'b0, 1'b1, 1'b1);
    rd(12'h000, 32'h00081000);
    card.levels(1'b0, 1'b0, 1'b0);
    wr(12'h008, 32'h0007FFFF);
    card.levels(1'b0, 1'b1, 1'b0);
    card.levels(1'b0, 1'b0, 1'b0);
    rd(12'h000, 32'h00002000);
    @(posedge clk) lowEvents <= 10'h3FF;
    @(posedge clk) lowEvents <= 10'h000;
    rd(12'h000, 32'h000023FF);
    print_verdict;
  end
endmodule
`default_nettype wire
